// file: hdl/output_mixer_routing_control.sv
// top: AXI4-Lite register bank steering the output routing switches
//
// What this block does
// - four independent speaker route enables connect either speaker path to either driver.
// - the earpiece mute bit 5 resets to 1 and silences the earpiece while set.
// - the earpiece attenuation bit 4 resets to 0; 1 gives 6 dB less gain.
// - earpiece mixer bits 4 and 3 route left and right output mixers, reset muted.
// - line pair one mode 1 is single-ended with left-to-positive and left/right-to-negative.
// - line pair one mode 0 is differential with left mixer and both input amps across both.
`timescale 1ns/1ps
module output_mixer_routing_control
	import outmix_pkg::*;
(
	// clock and reset
	input  wire logic                CLK,
	input  wire logic                RESET,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0]   S_AXI_AWADDR,
	input  wire logic                S_AXI_AWVALID,
	output logic                     S_AXI_AWREADY,
	// axi4-lite write data
	input  wire logic [31:0]         S_AXI_WDATA,
	input  wire logic [3:0]          S_AXI_WSTRB,
	input  wire logic                S_AXI_WVALID,
	output logic                     S_AXI_WREADY,
	// axi4-lite write response
	output logic [1:0]               S_AXI_BRESP,
	output logic                     S_AXI_BVALID,
	input  wire logic                S_AXI_BREADY,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0]   S_AXI_ARADDR,
	input  wire logic                S_AXI_ARVALID,
	output logic                     S_AXI_ARREADY,
	// axi4-lite read data
	output logic [31:0]              S_AXI_RDATA,
	output logic [1:0]               S_AXI_RRESP,
	output logic                     S_AXI_RVALID,
	input  wire logic                S_AXI_RREADY,
	// analogue switch controls
	output spk_route_t               SPK_ROUTE,
	output earpiece_t                EARPIECE,
	output line_one_t                LINE_ONE
);

	// ==========================================================================
	// write channel
	logic              aw_held_reg, aw_held_next;
	logic              w_held_reg,  w_held_next;
	logic [7:0]        aw_idx_reg,  aw_idx_next;
	logic [15:0]       wdata_reg,   wdata_next;
	logic [1:0]        wstrb_reg,   wstrb_next;
	logic              bvalid_reg,  bvalid_next;
	logic [1:0]        bresp_reg,   bresp_next;
	logic              do_write;
	logic              wr_hit;
	logic [5:0]        wr_sel;

	assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
	assign S_AXI_WREADY  = !w_held_reg && !bvalid_reg;
	// one write at a time: address and data wait while the answer stands
	assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;

	function automatic logic [5:0] decode(input logic [7:0] idx);
		decode = {idx == OUT_MISC_IDX, idx == LINE_VOL_IDX, idx == LINE_MIX_IDX,
			idx == EAR_MIX_IDX, idx == EAR_VOL_IDX, idx == SPK_ROUTE_IDX};
	endfunction : decode

	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next  = w_held_reg;
		aw_idx_next  = aw_idx_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		wr_sel       = decode(aw_idx_reg);
		wr_hit       = (wr_sel != 6'h00);
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_held_next = 1'b1;
			// word address: index is the byte address over four
			aw_idx_next  = S_AXI_AWADDR[9:2];
			if (S_AXI_AWADDR[1:0] != 2'h0) begin
				aw_idx_next = 8'hFF;
			end
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_held_next = 1'b1;
			wdata_next  = S_AXI_WDATA[15:0];
			wstrb_next  = S_AXI_WSTRB[1:0];
		end
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_reg && S_AXI_BREADY) begin
			bvalid_next = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_idx_reg  <= 8'h00;
			wdata_reg   <= 16'h0000;
			wstrb_reg   <= 2'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg  <= w_held_next;
			aw_idx_reg  <= aw_idx_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
		end
	end

	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP  = bresp_reg;

	// ==========================================================================
	// control registers
	logic [15:0] spk_val, ev_val, em_val, lm_val, lv_val, misc_val;

	ctrl_field_reg #(.MASK(SPK_ROUTE_MASK), .RST(SPK_ROUTE_RST)) u_spk (
		.clk(CLK), .reset(RESET), .wr_en(do_write && wr_sel[0]),
		.wr_data(wdata_reg), .wr_strb(wstrb_reg), .value(spk_val));
	ctrl_field_reg #(.MASK(EAR_VOL_MASK), .RST(EAR_VOL_RST)) u_ev (
		.clk(CLK), .reset(RESET), .wr_en(do_write && wr_sel[1]),
		.wr_data(wdata_reg), .wr_strb(wstrb_reg), .value(ev_val));
	ctrl_field_reg #(.MASK(EAR_MIX_MASK), .RST(EAR_MIX_RST)) u_em (
		.clk(CLK), .reset(RESET), .wr_en(do_write && wr_sel[2]),
		.wr_data(wdata_reg), .wr_strb(wstrb_reg), .value(em_val));
	ctrl_field_reg #(.MASK(LINE_MIX_MASK), .RST(LINE_MIX_RST)) u_lm (
		.clk(CLK), .reset(RESET), .wr_en(do_write && wr_sel[3]),
		.wr_data(wdata_reg), .wr_strb(wstrb_reg), .value(lm_val));
	ctrl_field_reg #(.MASK(LINE_VOL_MASK), .RST(LINE_VOL_RST)) u_lv (
		.clk(CLK), .reset(RESET), .wr_en(do_write && wr_sel[4]),
		.wr_data(wdata_reg), .wr_strb(wstrb_reg), .value(lv_val));
	ctrl_field_reg #(.MASK(OUT_MISC_MASK), .RST(OUT_MISC_RST)) u_misc (
		.clk(CLK), .reset(RESET), .wr_en(do_write && wr_sel[5]),
		.wr_data(wdata_reg), .wr_strb(wstrb_reg), .value(misc_val));

	// ==========================================================================
	// switch controls, straight from the stored bits
	logic se_mode;
	assign se_mode = lm_val[LM_MODE_BIT];

	always_comb begin
		SPK_ROUTE.left_spk_path_to_left_drv   = spk_val[SPK_LL_BIT];
		SPK_ROUTE.right_spk_path_to_left_drv  = spk_val[SPK_RL_BIT];
		SPK_ROUTE.left_spk_path_to_right_drv  = spk_val[SPK_LR_BIT];
		SPK_ROUTE.right_spk_path_to_right_drv = spk_val[SPK_RR_BIT];
		EARPIECE.earpiece_mute                = ev_val[EAR_MUTE_BIT];
		EARPIECE.earpiece_atten               = ev_val[EAR_ATTEN_BIT];
		EARPIECE.left_outmix_to_earpiece      = em_val[EAR_L_BIT];
		EARPIECE.right_outmix_to_earpiece     = em_val[EAR_R_BIT];
		LINE_ONE.line_pair_one_mode           = se_mode;
		LINE_ONE.line_pair_one_atten          = lv_val[LV_ATTEN_BIT];
		LINE_ONE.pos_mute                     = lv_val[LV_PMUTE_BIT];
		LINE_ONE.neg_mute                     = lv_val[LV_NMUTE_BIT];
		// the shared bit 0 means left-to-positive or left-across-both, by mode
		LINE_ONE.left_outmix_to_pos           = se_mode && lm_val[LM_LP_BIT];
		LINE_ONE.left_outmix_to_neg           = se_mode && lm_val[LM_LN_BIT];
		LINE_ONE.right_outmix_to_neg          = se_mode && lm_val[LM_RN_BIT];
		LINE_ONE.left_outmix_to_diff          = !se_mode && lm_val[LM_LP_BIT];
		LINE_ONE.left_input_amp_to_diff       = !se_mode && lm_val[LM_IL_BIT];
		LINE_ONE.right_input_amp_to_diff      = !se_mode && lm_val[LM_IR_BIT];
		// buffer is not forced on; software enables it before single-ended use
		LINE_ONE.midrail_buffer_enable        = misc_val[MISC_VBUF_BIT];
	end

	// ==========================================================================
	// read channel, one cycle answer
	logic        rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg,  rdata_next;
	logic [1:0]  rresp_reg,  rresp_next;
	logic [5:0]  rd_sel;
	logic [15:0] rd_word;

	// registers are read live, so a write answered earlier is already visible
	assign S_AXI_ARREADY = !rvalid_reg;

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		rd_sel      = decode(S_AXI_ARADDR[9:2]);
		if (S_AXI_ARADDR[1:0] != 2'h0) begin
			rd_sel = 6'h00;
		end
		rd_word = ({16{rd_sel[0]}} & spk_val) | ({16{rd_sel[1]}} & ev_val)
			| ({16{rd_sel[2]}} & em_val) | ({16{rd_sel[3]}} & lm_val)
			| ({16{rd_sel[4]}} & lv_val) | ({16{rd_sel[5]}} & misc_val);
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rvalid_next = 1'b1;
			rdata_next  = {16'h0000, rd_word};
			rresp_next  = (rd_sel != 6'h00) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && S_AXI_RREADY) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= RESP_OKAY;
		end else begin
			rvalid_reg <= rvalid_next;
			rdata_reg  <= rdata_next;
			rresp_reg  <= rresp_next;
		end
	end

	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA  = rdata_reg;
	assign S_AXI_RRESP  = rresp_reg;

	// ==========================================================================
	// assertions
	spk_route_reset_a: assert property (@(posedge CLK)
		$fell(RESET) |-> SPK_ROUTE == 4'h9 && EARPIECE == 4'h8)
		else $error("route or earpiece reset value wrong");

	spk_follows_write_a: assert property (@(posedge CLK) disable iff (RESET)
		do_write && wr_sel[0] && wstrb_reg[0] |=> SPK_ROUTE
			== {$past(wdata_reg[SPK_LL_BIT]), $past(wdata_reg[SPK_RL_BIT]),
			$past(wdata_reg[SPK_LR_BIT]), $past(wdata_reg[SPK_RR_BIT])})
		else $error("speaker route did not follow write");

	mute_follows_write_a: assert property (@(posedge CLK) disable iff (RESET)
		do_write && wr_sel[1] && wstrb_reg[0] |=> EARPIECE.earpiece_mute
			== $past(wdata_reg[EAR_MUTE_BIT]))
		else $error("earpiece mute did not follow write");

	atten_follows_write_a: assert property (@(posedge CLK) disable iff (RESET)
		do_write && wr_sel[1] && wstrb_reg[0] |=> EARPIECE.earpiece_atten
			== $past(wdata_reg[EAR_ATTEN_BIT]))
		else $error("earpiece attenuation did not follow write");

	earmix_write_a: assert property (@(posedge CLK) disable iff (RESET)
		do_write && wr_sel[2] && wstrb_reg[0] |=> {EARPIECE.left_outmix_to_earpiece,
			EARPIECE.right_outmix_to_earpiece} == $past(wdata_reg[4:3]))
		else $error("earpiece mixer route did not follow write");

	line_mode_write_a: assert property (@(posedge CLK) disable iff (RESET)
		do_write && wr_sel[3] && wstrb_reg[0] |=> LINE_ONE.line_pair_one_mode
			== $past(wdata_reg[LM_MODE_BIT]))
		else $error("line pair mode did not follow write");

	single_ended_a: assert property (@(posedge CLK) disable iff (RESET)
		!se_mode |-> !LINE_ONE.left_outmix_to_pos && !LINE_ONE.left_outmix_to_neg
			&& !LINE_ONE.right_outmix_to_neg)
		else $error("single-ended route active in differential mode");

	differential_a: assert property (@(posedge CLK) disable iff (RESET)
		se_mode |-> !LINE_ONE.left_outmix_to_diff && !LINE_ONE.left_input_amp_to_diff
			&& !LINE_ONE.right_input_amp_to_diff)
		else $error("differential route active in single-ended mode");

	midrail_write_a: assert property (@(posedge CLK) disable iff (RESET)
		do_write && wr_sel[5] && wstrb_reg[0] |=> LINE_ONE.midrail_buffer_enable
			== $past(wdata_reg[MISC_VBUF_BIT]))
		else $error("midrail buffer enable did not follow write");

	readback_a: assert property (@(posedge CLK) disable iff (RESET)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 10'h090
			|=> S_AXI_RVALID && S_AXI_RDATA == {27'h0000000, $past(spk_val[4:3]), 1'b0,
			$past(spk_val[1:0])})
		else $error("speaker route read-back mismatch");

	write_answer_a: assert property (@(posedge CLK) disable iff (RESET)
		do_write |=> S_AXI_BVALID && S_AXI_BRESP == ($past(wr_hit) ? RESP_OKAY : RESP_SLVERR))
		else $error("write not answered");

	read_answer_a: assert property (@(posedge CLK) disable iff (RESET)
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered");

	wr_cover_c: cover property (@(posedge CLK) disable iff (RESET)
		do_write && wr_sel[0]);
	rd_cover_c: cover property (@(posedge CLK) disable iff (RESET)
		S_AXI_RVALID && S_AXI_RREADY && S_AXI_RRESP == RESP_OKAY);
	se_cover_c: cover property (@(posedge CLK) disable iff (RESET)
		se_mode && LINE_ONE.midrail_buffer_enable);
	wr_error_c: cover property (@(posedge CLK) disable iff (RESET)
		S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
	ear_both_c: cover property (@(posedge CLK) disable iff (RESET)
		EARPIECE.earpiece_atten && EARPIECE.left_outmix_to_earpiece
		&& EARPIECE.right_outmix_to_earpiece);

endmodule : output_mixer_routing_control

// file: hdl/outmix_pkg.sv
// package: register map, field positions and reset values of the output routing block
package outmix_pkg;

	// ==========================================================================
	// register word indices; the byte address is four times the index
	localparam logic [7:0]  EAR_VOL_IDX     = 8'h1F;
	localparam logic [7:0]  SPK_ROUTE_IDX   = 8'h24;
	localparam logic [7:0]  EAR_MIX_IDX     = 8'h33;
	localparam logic [7:0]  LINE_MIX_IDX    = 8'h34;
	localparam logic [7:0]  LINE_VOL_IDX    = 8'h1E;
	localparam logic [7:0]  OUT_MISC_IDX    = 8'h40;
	localparam int          ADDR_W          = 10;

	// ==========================================================================
	// field positions
	localparam int SPK_LL_BIT    = 4;
	localparam int SPK_RL_BIT    = 3;
	localparam int SPK_LR_BIT    = 1;
	localparam int SPK_RR_BIT    = 0;
	localparam int EAR_MUTE_BIT  = 5;
	localparam int EAR_ATTEN_BIT = 4;
	localparam int EAR_L_BIT     = 4;
	localparam int EAR_R_BIT     = 3;
	localparam int LM_LN_BIT     = 6;
	localparam int LM_RN_BIT     = 5;
	localparam int LM_MODE_BIT   = 4;
	localparam int LM_IR_BIT     = 2;
	localparam int LM_IL_BIT     = 1;
	localparam int LM_LP_BIT     = 0;
	localparam int LV_NMUTE_BIT  = 6;
	localparam int LV_PMUTE_BIT  = 5;
	localparam int LV_ATTEN_BIT  = 4;
	localparam int MISC_VBUF_BIT = 0;

	// ==========================================================================
	// writable masks and reset values (16-bit registers)
	localparam logic [15:0] SPK_ROUTE_MASK  = 16'h001B;
	localparam logic [15:0] SPK_ROUTE_RST   = 16'h0011;
	localparam logic [15:0] EAR_VOL_MASK    = 16'h0030;
	localparam logic [15:0] EAR_VOL_RST     = 16'h0020;
	localparam logic [15:0] EAR_MIX_MASK    = 16'h0018;
	localparam logic [15:0] EAR_MIX_RST     = 16'h0000;
	localparam logic [15:0] LINE_MIX_MASK   = 16'h0077;
	localparam logic [15:0] LINE_MIX_RST    = 16'h0000;
	localparam logic [15:0] LINE_VOL_MASK   = 16'h0070;
	localparam logic [15:0] LINE_VOL_RST    = 16'h0060;
	localparam logic [15:0] OUT_MISC_MASK   = 16'h0001;
	localparam logic [15:0] OUT_MISC_RST    = 16'h0000;

	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// switch controls handed to the analogue side
	typedef struct packed {
		logic left_spk_path_to_left_drv;
		logic right_spk_path_to_left_drv;
		logic left_spk_path_to_right_drv;
		logic right_spk_path_to_right_drv;
	} spk_route_t;

	typedef struct packed {
		logic earpiece_mute;
		logic earpiece_atten;
		logic left_outmix_to_earpiece;
		logic right_outmix_to_earpiece;
	} earpiece_t;

	typedef struct packed {
		logic line_pair_one_mode;
		logic line_pair_one_atten;
		logic pos_mute;
		logic neg_mute;
		logic left_outmix_to_pos;
		logic left_outmix_to_neg;
		logic right_outmix_to_neg;
		logic left_outmix_to_diff;
		logic left_input_amp_to_diff;
		logic right_input_amp_to_diff;
		logic midrail_buffer_enable;
	} line_one_t;

endpackage : outmix_pkg

// file: hdl/ctrl_field_reg.sv
// one masked control register with reset value and read-back
`timescale 1ns/1ps
module ctrl_field_reg
	import outmix_pkg::*;
#(
	parameter logic [15:0] MASK = 16'h0000,
	parameter logic [15:0] RST  = 16'h0000
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// write side
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0]  wr_strb,
	// stored value
	output logic      [15:0] value
);

	logic [15:0] value_reg;
	logic [15:0] value_next;
	logic [15:0] lane_mask;

	always_comb begin
		lane_mask  = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & MASK;
		value_next = value_reg;
		if (wr_en) begin
			value_next = (value_reg & ~lane_mask) | (wr_data & lane_mask);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			value_reg <= RST;
		end else begin
			value_reg <= value_next;
		end
	end

	assign value = value_reg;

	stored_bits_a: assert property (@(posedge clk) disable iff (reset)
		!wr_en |=> ((value_reg & ~MASK) == 16'h0000) && (value_reg == $past(value_reg)))
		else $error("stored bits changed without a write");

endmodule : ctrl_field_reg

// file: testbench/test_output_mixer_routing_control.sv
// self-checking bench: register traffic over the bus and the switch outputs
`timescale 1ns/1ps
module test_output_mixer_routing_control
	import outmix_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [9:0]        aw_addr, ar_addr;
	logic              aw_valid, w_valid, b_ready, ar_valid, r_ready;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp;
	logic [31:0]       rdata;
	spk_route_t        spk;
	earpiece_t         ear;
	line_one_t         line;
	logic [15:0]       mdl [6];
	logic [9:0]        adr [6] = '{10'h07C, 10'h090, 10'h0CC, 10'h0D0, 10'h078, 10'h100};
	logic [15:0]       msk [6] = '{EAR_VOL_MASK, SPK_ROUTE_MASK, EAR_MIX_MASK,
		LINE_MIX_MASK, LINE_VOL_MASK, OUT_MISC_MASK};
	logic [15:0]       rsv [6] = '{EAR_VOL_RST, SPK_ROUTE_RST, EAR_MIX_RST,
		LINE_MIX_RST, LINE_VOL_RST, OUT_MISC_RST};
	logic [1:0]        bq [$];
	logic [33:0]       rq [$];
	logic [33:0]       e_r;
	int                num_errors = 0;
	int                n_checks = 0;
	int                cyc = 0;

	always #2 clk = ~clk;

	output_mixer_routing_control output_mixer_routing_control_inst (
		.CLK(clk), .RESET(rst),
		.S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(r_ready),
		.SPK_ROUTE(spk), .EARPIECE(ear), .LINE_ONE(line)
	);

	// ==========================================================
	// checking
	task cmp(input string n, input logic [33:0] e, input logic [33:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : cmp

	task test_done;
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// responses are taken off the queues in the cycle they are accepted
	always @(negedge clk) begin
		if (bvalid === 1'b1 && b_ready)
			cmp("write response", 34'(bq.pop_front()), 34'(bresp));
		if (rvalid === 1'b1 && r_ready) begin
			e_r = rq.pop_front();
			cmp("read response", 34'(e_r[33:32]), 34'(rresp));
			if (e_r[33:32] === RESP_OKAY)
				cmp("read data", 34'(e_r[31:0]), 34'(rdata));
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			num_errors++;
			test_done();
		end
	end

	task automatic chk_sw;
		logic        se;
		logic [10:0] le;
		@(negedge clk);
		se = mdl[3][4];
		le = {se, mdl[4][4], mdl[4][5], mdl[4][6], se & mdl[3][0], se & mdl[3][6],
			se & mdl[3][5], ~se & mdl[3][0], ~se & mdl[3][1], ~se & mdl[3][2], mdl[5][0]};
		cmp("speaker routes", 34'({mdl[1][4], mdl[1][3], mdl[1][1], mdl[1][0]}), 34'(spk));
		cmp("earpiece", 34'({mdl[0][5], mdl[0][4], mdl[2][4], mdl[2][3]}), 34'(ear));
		cmp("line one", 34'(le), 34'(line));
	endtask : chk_sw

	// ==========================================================
	// bus master
	function automatic int find(input logic [9:0] a);
		find = -1;
		for (int i = 0; i < 6; i++)
			if (adr[i] === a)
				find = i;
	endfunction : find

	task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [3:0] s);
		int          i;
		logic [15:0] m;
		logic        ta, tw, tb;
		i = find(a);
		m = {{8{s[1]}}, {8{s[0]}}} & ((i < 0) ? 16'h0000 : msk[i]);
		bq.push_back((i < 0) ? RESP_SLVERR : RESP_OKAY);
		if (i >= 0)
			mdl[i] = (mdl[i] & ~m) | (d & m);
		@(posedge clk);
		aw_addr <= a;
		aw_valid <= 1'b1;
		w_data <= {16'($urandom), d};
		w_strb <= s;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		do begin
			@(negedge clk);
			ta = aw_valid & awready;
			tw = w_valid & wready;
			tb = b_ready & bvalid;
			@(posedge clk);
			if (ta)
				aw_valid <= 1'b0;
			if (tw)
				w_valid <= 1'b0;
			if (tb)
				b_ready <= 1'b0;
		end while (tb !== 1'b1);
	endtask : wr

	task automatic rd(input logic [9:0] a);
		int   i;
		logic ta, tr;
		i = find(a);
		rq.push_back((i < 0) ? {RESP_SLVERR, 32'h00000000} : {RESP_OKAY, 16'h0000, mdl[i]});
		@(posedge clk);
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		do begin
			@(negedge clk);
			ta = ar_valid & arready;
			tr = r_ready & rvalid;
			@(posedge clk);
			if (ta)
				ar_valid <= 1'b0;
			if (tr)
				r_ready <= 1'b0;
		end while (tr !== 1'b1);
	endtask : rd

	task automatic rd_all;
		for (int i = 0; i < 6; i++)
			rd(adr[i]);
	endtask : rd_all

	// ==========================================================
	// tests
	initial begin
		logic [15:0] d;
		int          j;
		aw_addr = 10'h000;
		ar_addr = 10'h000;
		{aw_valid, w_valid, b_ready, ar_valid, r_ready} = 5'h00;
		w_data = 32'h00000000;
		w_strb = 4'h0;
		void'($urandom(32'h10664143));
		for (int i = 0; i < 6; i++)
			mdl[i] = rsv[i];
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		chk_sw();
		rd_all();
		$display("test reset values done");
		// unused bits set on purpose: they must read back as zero
		for (int k = 0; k < 16; k++) begin
			wr(10'h090, {11'h7FF, k[3], k[2], 1'b1, k[1], k[0]}, 4'h3);
			chk_sw();
			rd(10'h090);
		end
		$display("test speaker routes done");
		for (int k = 0; k < 4; k++) begin
			wr(10'h07C, {10'h3FF, k[1], k[0], 4'hF}, 4'h3);
			wr(10'h0CC, {11'h7FF, k[0], k[1], 3'h7}, 4'h3);
			chk_sw();
			rd(10'h07C);
			rd(10'h0CC);
		end
		$display("test earpiece done");
		wr(10'h100, 16'h0001, 4'h1);
		for (int k = 0; k < 8; k++) begin
			d = 16'($urandom);
			d[4] = k[0];
			wr(10'h0D0, d, 4'h3);
			wr(10'h078, 16'($urandom), 4'h1);
			chk_sw();
		end
		$display("test line pair done");
		wr(10'h07C, 16'h0000, 4'h2);
		wr(10'h3FC, 16'hFFFF, 4'hF);
		wr(10'h07D, 16'h0000, 4'hF);
		rd(10'h3FC);
		rd(10'h07D);
		chk_sw();
		rd_all();
		$display("test strobes and unmapped done");
		repeat (60) begin
			j = $urandom % 7;
			wr((j == 6) ? 10'h3FC : adr[j], 16'($urandom), 4'($urandom));
			chk_sw();
			if ($urandom % 2)
				rd((j == 6) ? 10'h3FC : adr[j]);
		end
		rd_all();
		$display("test random traffic done");
		test_done();
	end

endmodule : test_output_mixer_routing_control
